// >>> lbp_pkg.sv
// Contract
// (RL1) generate and detect PRBS7/11/15, QRSS, Daly
// (RL2) repeating user pattern of 1..32 bits
// (RL3) two 16-bit words alternating every 1..256
// (RL4) 32-bit bit counter, 24-bit error counter
// (RL5) sync, error, overflow events, each maskable
// (RL6) info register records events; host reads it
// (RL7) host configures mux before tester connects
// (RL8) status register flags tester changes of state
// (RL9) status bits set on event, clear on read
// (RL10) direction bit selects network or backplane side
// (RL11) per-channel selectors restrict slots per direction
// (RL12) T1 framing-bit use enables per direction
// (RL13) software replicates short patterns to 32 bits
// (RL14) least significant pattern bit goes first
// (RL15) pseudorandom modes use all-ones pattern bytes
// (RL16) first alternating word from lower two bytes
// (RL17) each word repeats alternating-count times
// (RL18) bit counter counts every bit while synced
// (RL19) error counter counts bad bits while synced
// (RL20) toggling latch-and-clear resets both counters
// (RL21) bit counter saturates, sets its overflow flag
// (RL22) error counter saturates, sets its overflow flag
// (RL23) sync after clean run; lose on error density
`default_nettype none
package lbp_pkg;
    // device register addresses
    localparam logic [7:0] A_CTL1 = 8'h00;
    localparam logic [7:0] A_CTL2 = 8'h01;
    localparam logic [7:0] A_IFC = 8'h02;
    localparam logic [7:0] A_AWC = 8'h03;
    localparam logic [7:0] A_PAT0 = 8'h04;
    localparam logic [7:0] A_BCNT0 = 8'h08;
    localparam logic [7:0] A_ECNT0 = 8'h0C;
    localparam logic [7:0] A_STAT = 8'h0F;
    localparam logic [7:0] A_INFO = 8'h10;
    localparam logic [7:0] A_TXSEL0 = 8'h14;
    localparam logic [7:0] A_RXSEL0 = 8'h18;
    // field positions
    localparam int CTL1_LC = 0;
    localparam int CTL1_MSYNC = 1;
    localparam int CTL1_MERR = 2;
    localparam int CTL1_MOVF = 3;
    localparam int IFC_ACT = 0;
    localparam int IFC_DIR = 1;
    localparam int IFC_RX_FRAMING_BIT_USE = 2;
    localparam int IFC_TX_FRAMING_BIT_USE = 3;
    localparam int EV_SYNC = 0;
    localparam int EV_ERR = 1;
    localparam int EV_BCO = 2;
    localparam int EV_ECO = 3;
    typedef enum logic [2:0] {PM_REP, PM_P7, PM_P11, PM_P15, PM_QRSS, PM_DALY, PM_ALT} lbp_mode_t;
    // synchroniser thresholds
    localparam logic [5:0] SYNC_RUN = 6'h20;
    localparam logic [5:0] LOSS_WIN = 6'h3F;
    localparam logic [3:0] LOSS_ERR = 4'h8;
    localparam logic [3:0] QRSS_ZMAX = 4'hE;
    localparam logic [0:7][7:0] DALY_TBL = {8'h80, 8'h80, 8'h00, 8'hFF, 8'h00, 8'h01, 8'h7E, 8'hAA};
    typedef struct packed {
        logic [19:0] lfsr;
        logic [4:0] idx;
        logic [7:0] wcnt;
        logic alt;
        logic [3:0] zrun;
        logic [2:0] dIdx;
    } lbp_gen_t;
    // host APB map
    localparam logic [7:0] H_CMD = 8'h00;
    localparam logic [7:0] H_STAT = 8'h04;
    localparam logic [7:0] H_PATREP = 8'h08;
    localparam logic [7:0] H_PATLEN = 8'h0C;
    localparam int CMD_WR = 16;
    localparam int HS_BUSY = 8;
    localparam int HS_ALERT = 9;
    localparam int PL_PRBS = 5;
    localparam logic [2:0] Q_ONE = 3'h1;
    localparam logic [2:0] Q_PAT = 3'h4;
endpackage
`default_nettype wire

// >>> lbp_if.sv
`timescale 1ns/100ps
`default_nettype none
interface lbp_if;
    logic [7:0] regAddr;
    logic [7:0] regWdata;
    logic regWr;
    logic regRd;
    logic [7:0] regRdata;
    logic regAck;
    logic alert;
    modport dev (input regAddr, regWdata, regWr, regRd, output regRdata, regAck, alert);
    modport host (output regAddr, regWdata, regWr, regRd, input regRdata, regAck, alert);
endinterface
`default_nettype wire

// >>> lbp_dev_end.sv
// Local design decisions: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module lbp_dev_end (
    input wire logic clk,
    input wire logic rst,
    lbp_if.dev bus,
    input wire logic bitEn,
    input wire logic [4:0] chanIdx,
    input wire logic fBit,
    input wire logic t1Mode,
    input wire logic netTxIn,
    input wire logic netRxIn,
    output logic txLineOut,
    output logic bpRxOut,
    output logic inSync
);
    typedef enum logic {SY_HUNT, SY_LOCK} lbp_sync_t;
    typedef struct packed {
        logic [7:0] ctl1;
        lbp_pkg::lbp_mode_t mode;
        logic [3:0] ifc;
        logic [7:0] awc;
        logic [31:0] pat;
        logic [31:0] txSel;
        logic [31:0] rxSel;
        lbp_pkg::lbp_gen_t gen;
        lbp_pkg::lbp_gen_t chk;
        lbp_sync_t syncSt;
        logic [5:0] goodRun;
        logic [5:0] winCnt;
        logic [3:0] winErr;
        logic [31:0] bitCnt;
        logic [23:0] errCnt;
        logic [31:0] bitSnap;
        logic [23:0] errSnap;
        logic lcPrev;
        logic [3:0] status;
        logic [3:0] info;
        logic [7:0] rdata;
        logic ack;
        logic alert;
        logic txOut;
        logic bpOut;
    } lbp_dev_st_t;

    lbp_dev_st_t r_r;
    lbp_dev_st_t r_nxt;

    function automatic logic lfsrFb(input logic [19:0] s, input lbp_pkg::lbp_mode_t m);
        case (m)
            lbp_pkg::PM_P7: lfsrFb = s[6] ^ s[5]; // RL1
            lbp_pkg::PM_P11: lfsrFb = s[10] ^ s[8]; // RL1
            lbp_pkg::PM_P15: lfsrFb = s[14] ^ s[13]; // RL1
            default: lfsrFb = s[19] ^ s[16];
        endcase
    endfunction

    function automatic logic patBit(input lbp_pkg::lbp_gen_t g, input lbp_pkg::lbp_mode_t m,
                                    input logic [31:0] p);
        case (m)
            lbp_pkg::PM_REP: patBit = p[g.idx]; // RL2 RL14
            lbp_pkg::PM_ALT: patBit = p[{g.alt, g.idx[3:0]}]; // RL3 RL16
            lbp_pkg::PM_DALY: patBit = lbp_pkg::DALY_TBL[g.dIdx][g.idx[2:0]]; // RL1
            // long zero runs forced to one, as quasi-random signals need
            lbp_pkg::PM_QRSS: patBit = (g.zrun >= lbp_pkg::QRSS_ZMAX) | lfsrFb(g.lfsr, m); // RL1
            default: patBit = lfsrFb(g.lfsr, m);
        endcase
    endfunction

    function automatic lbp_pkg::lbp_gen_t advance(input lbp_pkg::lbp_gen_t g,
                                                  input lbp_pkg::lbp_mode_t m,
                                                  input logic [7:0] awc,
                                                  input logic seedEn,
                                                  input logic seedBit);
        lbp_pkg::lbp_gen_t n;
        logic raw;
        n = g;
        raw = lfsrFb(g.lfsr, m);
        n.lfsr = {g.lfsr[18:0], seedEn ? seedBit : raw};
        n.zrun = raw ? 4'h0 : (&g.zrun ? g.zrun : g.zrun + 4'h1);
        n.idx = (m == lbp_pkg::PM_ALT) ? {1'b0, g.idx[3:0] + 4'h1} : g.idx + 5'h01;
        // count 0 means 256 words through the 8-bit wrap
        if (m == lbp_pkg::PM_ALT && &g.idx[3:0]) begin
            if (g.wcnt + 8'h01 == awc) begin // RL17
                n.wcnt = 8'h00;
                n.alt = ~g.alt; // RL3
            end else begin
                n.wcnt = g.wcnt + 8'h01;
            end
        end
        if (&g.idx[2:0]) begin
            n.dIdx = g.dIdx + 3'h1;
        end
        return n;
    endfunction

    function automatic lbp_pkg::lbp_gen_t seed(input logic [31:0] p);
        lbp_pkg::lbp_gen_t n;
        n = '0;
        // an all-zero register would lock the shift register
        n.lfsr = p[19:0] | {19'h0, ~|p[19:0]}; // RL15
        return n;
    endfunction

    always_comb begin
        logic txSlot;
        logic rxSlot;
        logic act;
        logic dir;
        logic genSlot;
        logic chkSlot;
        logic rxBit;
        logic genBit;
        logic err;
        logic prbs;
        logic reseed;
        logic [3:0] ev;
        logic [3:0] winSum;
        logic [4:0] bo;
        reseed = 1'b0;
        ev = 4'h0;
        winSum = 4'h0;
        bo = 5'h00;
        r_nxt = r_r;
        r_nxt.ack = 1'b0;
        txSlot = fBit ? (t1Mode & r_r.ifc[lbp_pkg::IFC_TX_FRAMING_BIT_USE]) : r_r.txSel[chanIdx]; // RL11 RL12
        rxSlot = fBit ? (t1Mode & r_r.ifc[lbp_pkg::IFC_RX_FRAMING_BIT_USE]) : r_r.rxSel[chanIdx]; // RL11 RL12
        act = r_r.ifc[lbp_pkg::IFC_ACT]; // RL7
        dir = r_r.ifc[lbp_pkg::IFC_DIR]; // RL10
        genSlot = act & (dir ? rxSlot : txSlot);
        chkSlot = act & (dir ? txSlot : rxSlot);
        rxBit = dir ? netTxIn : netRxIn; // RL10
        genBit = patBit(r_r.gen, r_r.mode, r_r.pat);
        err = rxBit ^ patBit(r_r.chk, r_r.mode, r_r.pat);
        prbs = r_r.mode inside {[lbp_pkg::PM_P7:lbp_pkg::PM_QRSS]};

        if (bitEn) begin
            r_nxt.txOut = (act & ~dir & txSlot) ? genBit : netTxIn; // RL10
            r_nxt.bpOut = (act & dir & rxSlot) ? genBit : netRxIn; // RL10
            if (genSlot) begin
                r_nxt.gen = advance(r_r.gen, r_r.mode, r_r.awc, 1'b0, 1'b0);
            end
        end

        if (bitEn && chkSlot) begin
            if (r_r.syncSt == SY_HUNT) begin
                // prbs hunts by self-seeding; fixed patterns slip one bit per miss
                if (prbs) begin
                    r_nxt.chk = advance(r_r.chk, r_r.mode, r_r.awc, 1'b1, rxBit);
                end else if (!err) begin
                    r_nxt.chk = advance(r_r.chk, r_r.mode, r_r.awc, 1'b0, 1'b0);
                end
                r_nxt.goodRun = err ? 6'h00 : r_r.goodRun + 6'h01;
                if (!err && r_r.goodRun == lbp_pkg::SYNC_RUN - 6'h01) begin // RL23
                    r_nxt.syncSt = SY_LOCK;
                    r_nxt.winCnt = 6'h00;
                    r_nxt.winErr = 4'h0;
                    ev[lbp_pkg::EV_SYNC] = 1'b1;
                end
            end else begin
                r_nxt.chk = advance(r_r.chk, r_r.mode, r_r.awc, 1'b0, 1'b0);
                if (~&r_r.bitCnt) begin
                    r_nxt.bitCnt = r_r.bitCnt + 32'h00000001; // RL18
                    ev[lbp_pkg::EV_BCO] = &r_nxt.bitCnt; // RL21
                end
                if (err) begin
                    ev[lbp_pkg::EV_ERR] = 1'b1;
                    if (~&r_r.errCnt) begin
                        r_nxt.errCnt = r_r.errCnt + 24'h000001; // RL19
                        ev[lbp_pkg::EV_ECO] = &r_nxt.errCnt; // RL22
                    end
                end
                winSum = r_r.winErr + {3'h0, err};
                r_nxt.winCnt = r_r.winCnt + 6'h01;
                r_nxt.winErr = winSum;
                if (winSum >= lbp_pkg::LOSS_ERR) begin // RL23
                    r_nxt.syncSt = SY_HUNT;
                    r_nxt.goodRun = 6'h00;
                    ev[lbp_pkg::EV_SYNC] = 1'b1;
                end else if (r_r.winCnt == lbp_pkg::LOSS_WIN) begin
                    r_nxt.winErr = 4'h0;
                end
            end
        end

        // latch on the rising edge of the bit, then clear live counts
        r_nxt.lcPrev = r_r.ctl1[lbp_pkg::CTL1_LC];
        if (r_r.ctl1[lbp_pkg::CTL1_LC] && !r_r.lcPrev) begin
            r_nxt.bitSnap = r_r.bitCnt;
            r_nxt.errSnap = r_r.errCnt;
            r_nxt.bitCnt = 32'h00000000; // RL20
            r_nxt.errCnt = 24'h000000; // RL20
        end

        if (bus.regWr) begin
            r_nxt.ack = 1'b1;
            if (bus.regAddr[7:2] == lbp_pkg::A_PAT0[7:2]) begin
                r_nxt.pat[{bus.regAddr[1:0], 3'h0} +: 8] = bus.regWdata;
                reseed = 1'b1;
            end else if (bus.regAddr[7:2] == lbp_pkg::A_TXSEL0[7:2]) begin
                r_nxt.txSel[{bus.regAddr[1:0], 3'h0} +: 8] = bus.regWdata; // RL11
            end else if (bus.regAddr[7:2] == lbp_pkg::A_RXSEL0[7:2]) begin
                r_nxt.rxSel[{bus.regAddr[1:0], 3'h0} +: 8] = bus.regWdata; // RL11
            end else if (bus.regAddr == lbp_pkg::A_CTL1) begin
                r_nxt.ctl1 = bus.regWdata;
            end else if (bus.regAddr == lbp_pkg::A_CTL2) begin
                r_nxt.mode = lbp_pkg::lbp_mode_t'(bus.regWdata[2:0]);
                reseed = 1'b1;
            end else if (bus.regAddr == lbp_pkg::A_IFC) begin
                r_nxt.ifc = bus.regWdata[3:0];
            end else if (bus.regAddr == lbp_pkg::A_AWC) begin
                r_nxt.awc = bus.regWdata;
            end
        end
        if (reseed) begin
            r_nxt.gen = seed(r_nxt.pat);
            r_nxt.chk = seed(r_nxt.pat);
            r_nxt.syncSt = SY_HUNT;
            r_nxt.goodRun = 6'h00;
        end

        // a fresh event beats the read that clears its flag
        r_nxt.status = ((bus.regRd && bus.regAddr == lbp_pkg::A_STAT) ? 4'h0 : r_r.status)
                       | ev; // RL8 RL9
        bo = {1'b0, ev} & ~{1'b0, r_r.ctl1[lbp_pkg::CTL1_MOVF], r_r.ctl1[lbp_pkg::CTL1_MOVF],
                            r_r.ctl1[lbp_pkg::CTL1_MERR], r_r.ctl1[lbp_pkg::CTL1_MSYNC]}; // RL5
        r_nxt.info = ((bus.regRd && bus.regAddr == lbp_pkg::A_INFO) ? 4'h0 : r_r.info)
                     | bo[3:0]; // RL6
        r_nxt.alert = |r_nxt.info; // RL6

        if (bus.regRd) begin
            r_nxt.ack = 1'b1;
            r_nxt.rdata = 8'h00;
            if (bus.regAddr == lbp_pkg::A_STAT) begin
                r_nxt.rdata = {3'h0, r_r.syncSt == SY_LOCK, r_r.status};
            end else if (bus.regAddr[7:2] == lbp_pkg::A_PAT0[7:2]) begin
                r_nxt.rdata = r_r.pat[{bus.regAddr[1:0], 3'h0} +: 8];
            end else if (bus.regAddr[7:2] == lbp_pkg::A_BCNT0[7:2]) begin
                r_nxt.rdata = r_r.bitSnap[{bus.regAddr[1:0], 3'h0} +: 8]; // RL4
            end else if (bus.regAddr[7:2] == lbp_pkg::A_ECNT0[7:2]) begin
                r_nxt.rdata = r_r.errSnap[{bus.regAddr[1:0], 3'h0} +: 8]; // RL4
            end else if (bus.regAddr[7:2] == lbp_pkg::A_TXSEL0[7:2]) begin
                r_nxt.rdata = r_r.txSel[{bus.regAddr[1:0], 3'h0} +: 8];
            end else if (bus.regAddr[7:2] == lbp_pkg::A_RXSEL0[7:2]) begin
                r_nxt.rdata = r_r.rxSel[{bus.regAddr[1:0], 3'h0} +: 8];
            end else if (bus.regAddr == lbp_pkg::A_CTL1) begin
                r_nxt.rdata = r_r.ctl1;
            end else if (bus.regAddr == lbp_pkg::A_CTL2) begin
                r_nxt.rdata = {5'h00, r_r.mode};
            end else if (bus.regAddr == lbp_pkg::A_IFC) begin
                r_nxt.rdata = {4'h0, r_r.ifc};
            end else if (bus.regAddr == lbp_pkg::A_AWC) begin
                r_nxt.rdata = r_r.awc;
            end else if (bus.regAddr == lbp_pkg::A_INFO) begin
                r_nxt.rdata = {4'h0, r_r.info};
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            r_r <= '0;
        end else begin
            r_r <= r_nxt;
        end
    end

    assign bus.regRdata = r_r.rdata;
    assign bus.regAck = r_r.ack;
    assign bus.alert = r_r.alert;
    assign txLineOut = r_r.txOut;
    assign bpRxOut = r_r.bpOut;
    assign inSync = (r_r.syncSt == SY_LOCK);
endmodule
`default_nettype wire

// >>> lbp_host_end.sv
`timescale 1ns/100ps
`default_nettype none
module lbp_host_end (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    lbp_if.host bus
);
    typedef enum logic {HF_IDLE, HF_WAIT} lbp_hfsm_t;
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic [7:0] regAddr;
        logic [7:0] regWdata;
        logic regWr;
        logic regRd;
        lbp_hfsm_t fsm;
        logic [2:0] qCnt;
        logic qWrite;
        logic [7:0] qAddr;
        logic [31:0] qData;
        logic [7:0] lastRd;
        logic [5:0] patLen;
    } lbp_host_st_t;

    lbp_host_st_t h_r;
    lbp_host_st_t h_nxt;

    // spread a short pattern over all 32 bits, first bit at bit 0
    function automatic logic [31:0] replicate(input logic [31:0] p, input logic [4:0] lenM1);
        logic [31:0] o;
        int k;
        o = 32'h00000000;
        for (int i = 0; i < 32; i++) begin
            k = i % (int'(lenM1) + 1);
            o[i] = p[k[4:0]]; // RL13 RL14
        end
        return o;
    endfunction

    always_comb begin
        logic busy;
        logic setup;
        logic access;
        busy = (h_r.qCnt != 3'h0) || (h_r.fsm == HF_WAIT);
        setup = psel & ~penable;
        access = psel & penable & h_r.pready;
        h_nxt = h_r;
        h_nxt.regWr = 1'b0;
        h_nxt.regRd = 1'b0;
        h_nxt.pready = 1'b0;
        h_nxt.pslverr = 1'b0;

        if (setup) begin
            h_nxt.pready = 1'b1;
            h_nxt.prdata = 32'h00000000;
            case (paddr)
                lbp_pkg::H_CMD, lbp_pkg::H_PATREP: h_nxt.pslverr = pwrite & busy;
                lbp_pkg::H_STAT: begin
                    h_nxt.prdata[7:0] = h_r.lastRd;
                    h_nxt.prdata[lbp_pkg::HS_BUSY] = busy;
                    h_nxt.prdata[lbp_pkg::HS_ALERT] = bus.alert; // RL6
                end
                lbp_pkg::H_PATLEN: h_nxt.prdata[5:0] = h_r.patLen;
                default: h_nxt.pslverr = 1'b1;
            endcase
        end

        if (access && pwrite && !h_r.pslverr) begin
            case (paddr)
                lbp_pkg::H_CMD: begin
                    h_nxt.qCnt = lbp_pkg::Q_ONE;
                    h_nxt.qWrite = pwdata[lbp_pkg::CMD_WR];
                    h_nxt.qAddr = pwdata[15:8];
                    h_nxt.qData = {24'h000000, pwdata[7:0]};
                end
                lbp_pkg::H_PATREP: begin
                    h_nxt.qCnt = lbp_pkg::Q_PAT;
                    h_nxt.qWrite = 1'b1;
                    h_nxt.qAddr = lbp_pkg::A_PAT0;
                    h_nxt.qData = h_r.patLen[lbp_pkg::PL_PRBS] ? 32'hFFFFFFFF // RL15
                                  : replicate(pwdata, h_r.patLen[4:0]); // RL13
                end
                lbp_pkg::H_PATLEN: h_nxt.patLen = pwdata[5:0];
                default: h_nxt.patLen = h_r.patLen;
            endcase
        end

        unique case (h_r.fsm)
            HF_IDLE: begin
                if (h_r.qCnt != 3'h0) begin
                    h_nxt.regAddr = h_r.qAddr;
                    h_nxt.regWdata = h_r.qData[7:0];
                    h_nxt.regWr = h_r.qWrite;
                    h_nxt.regRd = ~h_r.qWrite;
                    h_nxt.fsm = HF_WAIT;
                end
            end
            HF_WAIT: begin
                if (bus.regAck) begin
                    if (!h_r.qWrite) begin
                        h_nxt.lastRd = bus.regRdata;
                    end
                    h_nxt.qCnt = h_r.qCnt - 3'h1;
                    h_nxt.qAddr = h_r.qAddr + 8'h01;
                    h_nxt.qData = {8'h00, h_r.qData[31:8]};
                    h_nxt.fsm = HF_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            h_r <= '0;
        end else begin
            h_r <= h_nxt;
        end
    end

    assign prdata = h_r.prdata;
    assign pready = h_r.pready;
    assign pslverr = h_r.pslverr;
    assign bus.regAddr = h_r.regAddr;
    assign bus.regWdata = h_r.regWdata;
    assign bus.regWr = h_r.regWr;
    assign bus.regRd = h_r.regRd;
endmodule
`default_nettype wire

// >>> lbp_link_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module lbp_link_monitor (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [7:0] regRdata,
    input wire logic regAck,
    input wire logic alert
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    wire logic stb = regWr || regRd;
    wire logic infoRd = regRd && regAddr == lbp_pkg::A_INFO;
    property p_ack; stb |=> regAck; endproperty
    a_ack: assert property (p_ack) else $error("strobe not acked");
    property p_ackCause; regAck |-> $past(stb); endproperty
    a_ackCause: assert property (p_ackCause) else $error("ack with no strobe");
    property p_ackPulse; regAck |=> !regAck; endproperty
    a_ackPulse: assert property (p_ackPulse) else $error("ack too long");
    property p_oneOut; stb |=> !stb; endproperty
    a_oneOut: assert property (p_oneOut) else $error("strobe too long");
    property p_noBoth; !(regWr && regRd); endproperty
    a_noBoth: assert property (p_noBoth) else $error("read and write together");
    property p_rdHold; !$past(regRd) |-> $stable(regRdata); endproperty
    a_rdHold: assert property (p_rdHold) else $error("read data moved");
    property p_infoSet; infoRd && alert |=> regRdata != 8'h00; endproperty
    a_infoSet: assert property (p_infoSet) else $error("alert with empty info");
    property p_alertFall; $fell(alert) |-> infoRd || $past(infoRd) || $past(infoRd, 2); endproperty
    a_alertFall: assert property (p_alertFall) else $error("alert dropped unread");
    c_clear: cover property (regWr && regAddr == lbp_pkg::A_CTL1 && regWdata[0]);
    c_info: cover property (infoRd ##1 regAck);
    c_fall: cover property ($fell(alert));
endmodule
`default_nettype wire

// >>> line_bert_pattern_engine_tb.sv
`timescale 1ns/100ps
`default_nettype none
module line_bert_pattern_engine_tb;
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic bitEn = 1'b0, run = 1'b0, flip = 1'b0, dirBp = 1'b0, txRnd = 1'b0, rerr;
    logic fBit = 1'b0, t1Mode = 1'b1;
    logic [7:0] paddr = 8'h00;
    logic [4:0] chanIdx = 5'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdat, v, rnd;
    logic pready, pslverr, txLineOut, bpRxOut, inSync, netTxIn, netRxIn;
    integer seed = 32'hAFCAA26C;
    int errors = 0, checksDone = 0, cyc = 0, nBits = 0, n0;
    lbp_if lnk();
    lbp_dev_end lbp_dev_end_inst (.clk(clk), .rst(rst), .bus(lnk.dev), .bitEn(bitEn),
        .chanIdx(chanIdx), .fBit(fBit), .t1Mode(t1Mode), .netTxIn(netTxIn),
        .netRxIn(netRxIn), .txLineOut(txLineOut), .bpRxOut(bpRxOut), .inSync(inSync));
    lbp_host_end lbp_host_end_inst (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .bus(lnk.host));
    lbp_link_monitor lbp_link_monitor_inst (.clk(clk), .rst(rst), .regAddr(lnk.regAddr),
        .regWdata(lnk.regWdata), .regWr(lnk.regWr), .regRd(lnk.regRd),
        .regRdata(lnk.regRdata), .regAck(lnk.regAck), .alert(lnk.alert));
    // loop the generated stream back; flip inverts it to inject bit errors
    assign netRxIn = txLineOut ^ flip;
    assign netTxIn = dirBp ? bpRxOut ^ flip : txRnd;
    initial forever #10 clk = ~clk;
    always @(posedge clk) begin
        rnd = $random(seed);
        bitEn <= run & rnd[0];
        chanIdx <= rnd[8:4];
        fBit <= rnd[16];
        txRnd <= rnd[12];
        nBits <= nBits + int'(bitEn);
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            errors = errors + 1;
            conclude();
        end
    end
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checksDone = checksDone + 1;
        if (seen !== exp) begin
            errors = errors + 1;
            $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task conclude;
        $display("checks %0d errors %0d", checksDone, errors);
        if (errors == 0 && checksDone > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task idle;
        rdat = 32'h100;
        while (rdat[lbp_pkg::HS_BUSY] !== 1'b0)
            apb(1'b0, lbp_pkg::H_STAT, 32'h0);
    endtask
    task dev(input logic w, input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, lbp_pkg::H_CMD, {15'h0, w, a, d});
        idle();
    endtask
    task readN(input logic [7:0] a, input int n);
        v = 32'h0;
        for (int i = 0; i < n; i++) begin
            dev(1'b0, a + 8'(i), 8'h00);
            v[8 * i +: 8] = rdat[7:0];
        end
    endtask
    task waitSync;
        for (int i = 0; i < 8000 && inSync !== 1'b1; i++)
            @(posedge clk);
        check(inSync, 1'b1);
    endtask
    task inject;
        flip <= 1'b1;
        do @(posedge clk); while (bitEn !== 1'b1);
        flip <= 1'b0;
        repeat (40) @(posedge clk);
    endtask
    // phase is free, so accept any rotation of the 32-bit period
    task rotChk(input logic [31:0] pat);
        logic [31:0] b;
        logic [63:0] w;
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < 32; i++) begin
            do @(posedge clk); while (bitEn !== 1'b1);
            b[i] = dirBp ? bpRxOut : txLineOut;
        end
        for (int k = 0; k < 32; k++) begin
            w = {pat, pat} >> k;
            hit = hit | (w[31:0] === b);
        end
        check(hit, 1'b1);
    endtask
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        apb(1'b0, 8'h40, 32'h0);
        check(rerr, 1'b1);
        for (int i = 0; i < 4; i++) begin
            dev(1'b1, lbp_pkg::A_TXSEL0 + 8'(i), 8'hFF);
            dev(1'b1, lbp_pkg::A_RXSEL0 + 8'(i), 8'hFF);
        end
        apb(1'b1, lbp_pkg::H_PATLEN, 32'h4);
        apb(1'b1, lbp_pkg::H_PATREP, 32'hD);
        idle();
        readN(lbp_pkg::A_PAT0, 4);
        check(v, 32'h5AD6B5AD);
        dev(1'b1, lbp_pkg::A_CTL2, 8'h0);
        dev(1'b1, lbp_pkg::A_IFC, 8'hD);
        run <= 1'b1;
        waitSync();
        rotChk(32'h5AD6B5AD);
        $display("test repeat done");
        run <= 1'b0;
        repeat (4) @(posedge clk);
        dev(1'b1, lbp_pkg::A_CTL1, 8'h1);
        dev(1'b1, lbp_pkg::A_CTL1, 8'h0);
        n0 = nBits;
        run <= 1'b1;
        repeat (3) inject();
        run <= 1'b0;
        repeat (4) @(posedge clk);
        dev(1'b1, lbp_pkg::A_CTL1, 8'h1);
        readN(lbp_pkg::A_BCNT0, 4);
        check(v, nBits - n0);
        readN(lbp_pkg::A_ECNT0, 3);
        check(v, 32'h3);
        dev(1'b0, lbp_pkg::A_STAT, 8'h0);
        check(rdat[lbp_pkg::EV_ERR], 1'b1);
        check(lnk.alert, 1'b1);
        dev(1'b0, lbp_pkg::A_STAT, 8'h0);
        check(rdat[lbp_pkg::EV_ERR], 1'b0);
        dev(1'b0, lbp_pkg::A_INFO, 8'h0);
        check(rdat[lbp_pkg::EV_ERR], 1'b1);
        check(lnk.alert, 1'b0);
        dev(1'b1, lbp_pkg::A_CTL1, 8'h4);
        run <= 1'b1;
        inject();
        dev(1'b0, lbp_pkg::A_INFO, 8'h0);
        check(rdat[lbp_pkg::EV_ERR], 1'b0);
        $display("test counters done");
        dev(1'b1, lbp_pkg::A_AWC, 8'h1);
        for (int m = 1; m < 7; m++) begin
            apb(1'b1, lbp_pkg::H_PATLEN, m == 6 ? 32'h1F : 32'h20);
            apb(1'b1, lbp_pkg::H_PATREP, 32'h7E7E0000);
            idle();
            readN(lbp_pkg::A_PAT0, 4);
            check(v, m == 6 ? 32'h7E7E0000 : 32'hFFFFFFFF);
            dev(1'b1, lbp_pkg::A_CTL2, 8'(m));
            waitSync();
        end
        rotChk(32'h7E7E0000);
        dirBp <= 1'b1;
        dev(1'b1, lbp_pkg::A_IFC, 8'hF);
        dev(1'b1, lbp_pkg::A_CTL2, 8'h6);
        waitSync();
        rotChk(32'h7E7E0000);
        // a long inverted run must break the lock, then it must come back
        flip <= 1'b1;
        repeat (100) @(posedge clk);
        flip <= 1'b0;
        check(inSync, 1'b0);
        waitSync();
        $display("test modes done");
        conclude();
    end
endmodule
`default_nettype wire
